// file: verilog/rstcause_pkg.sv
package rstcause_pkg;
  localparam logic [7:0] STATUS_IDX = 8'h03;
  localparam logic [7:0] PWRCTL_IDX = 8'h8E;
  localparam logic [11:0] OFS_STATUS = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [11:0] OFS_PWRCTL = {2'b00, PWRCTL_IDX, 2'b00};
  localparam logic [11:0] OFS_CTRL = 12'h400;
  localparam logic [11:0] OFS_PC = 12'h404;
  localparam logic [11:0] OFS_DELAY = 12'h408;
  localparam logic [11:0] OFS_OPTDIR = 12'h40C;
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POWERON = 1;
  localparam int BIT_PD = 3;
  localparam int BIT_TO = 4;
  localparam logic [7:0] STATUS_POR_VAL = 8'h18;
  localparam logic [1:0] PWRCTL_MASK = 2'h3;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_VECTOR = 13'h0004;
  localparam logic [7:0] PCL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [5:0] DIR_RESET = 6'h3F;
  localparam int OST_PERIODS = 1024;
  localparam int PWRT_US = 72000;
  localparam int CLK_MHZ = 20;
  localparam int PWRT_CYCLES = PWRT_US * CLK_MHZ;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    OSC_LOW = 3'h0,
    OSC_MEDIUM = 3'h1,
    OSC_HIGH = 3'h2,
    OSC_RC = 3'h3,
    OSC_EXT = 3'h4,
    OSC_INT = 3'h5
  } osc_mode_type;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_PWRT = 3'b010,
    ST_OST = 3'b100
  } seq_state_type;
endpackage : rstcause_pkg

// file: verilog/startup_timer_if.sv
`timescale 1ns/1ps
interface startup_timer_if;
  logic start;
  logic [31:0] load;
  logic busy;
  logic done;
  modport ctrl (output start, output load, input busy, input done);
  modport tmr (input start, input load, output busy, output done);
endinterface : startup_timer_if

// file: verilog/startup_timer.sv
`timescale 1ns/1ps
module startup_timer (
  input wire logic clk,
  input wire logic rst,
  startup_timer_if.tmr t
);
  logic [31:0] cnt_r;
  logic done_r;
  assign t.busy = (cnt_r != 32'h0);
  assign t.done = done_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == 32'h1) || (t.start && t.load == 32'h0);
      if (t.start) cnt_r <= t.load;
      else if (cnt_r != 32'h0) cnt_r <= cnt_r - 32'h1;
    end
  end
endmodule : startup_timer

// file: verilog/reset_cause_status_logic.sv
`timescale 1ns/1ps
// Behaviour
// - Brown-out flag is bit 0 of the power-control register and is cleared by a brown-out reset.
// - With the brown-out detector disabled the brown-out flag has no defined meaning.
// - Power-on flag is bit 1, forced to 0 by power-on reset, set to 1 by brown-out reset and kept on other resets.
// - Power-control register sits at 8Eh with only bits 1 and 0, upper bits read 0.
// - Crystal modes wait power-up delay plus 1024 periods, others only the power-up delay.
// - Reset cause is encoded in power-on, brown-out, time-out and power-down bits per event.
// - Resets load the program counter with 000h, wake-ups continue at the next address.
// - Interrupt wake-up with global enable runs the next instruction then goes to the vector.
// - Status at 03h takes 0001 1xxx on power-on or brown-out, other resets clear upper bits, wake-ups keep them.
// - External and watchdog resets apply non-power-up reset values; brown-out applies the power-up values.
// - Resets clear program counter low and set option and pin-direction to all ones.
// - Watchdog wake-up leaves option and pin-direction untouched, changing only time-out, power-down and the program counter.
// - Power-up delay is fixed and used only after power-on or brown-out when enabled.
module reset_cause_status_logic
  import rstcause_pkg::*;
#(
  parameter int PWRT_COUNT = PWRT_CYCLES,
  parameter int OST_COUNT = OST_PERIODS
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic POWERON_EVT,
  input wire logic BROWNOUT_EVT,
  input wire logic EXT_RESET_EVT,
  input wire logic WATCHDOG_EVT,
  input wire logic INT_WAKE_EVT,
  input wire logic SLEEPING,
  input wire logic GLOBAL_INTERRUPT_ENABLE,
  input wire logic POWERUP_TIMER_DISABLE,
  input wire logic BROWNOUT_DETECTOR_ENABLE,
  input wire logic [2:0] OSC_MODE,
  input wire logic [12:0] PC_IN,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic CORE_RESET,
  output logic [12:0] PC_LOAD,
  output logic PC_LOAD_STB,
  output logic [7:0] OPTION_VALUE,
  output logic [5:0] PIN_DIRECTION
);
  if (PWRT_COUNT < 1 || OST_COUNT < 1) begin : g_bad_counts
    $error("bad startup counts");
  end
  // Synchronisers for event and configuration inputs
  logic [6:0] s1_r, s2_r, s3_r;
  logic [4:0] c1_r, c2_r;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s1_r <= 7'h0;
      s2_r <= 7'h0;
      s3_r <= 7'h0;
      c1_r <= 5'h00;
      c2_r <= 5'h00;
    end else begin
      s1_r <= {SLEEPING, INT_WAKE_EVT, WATCHDOG_EVT, EXT_RESET_EVT, BROWNOUT_EVT, POWERON_EVT,
               GLOBAL_INTERRUPT_ENABLE};
      s2_r <= s1_r;
      s3_r <= s2_r;
      c1_r <= {BROWNOUT_DETECTOR_ENABLE, POWERUP_TIMER_DISABLE, OSC_MODE};
      c2_r <= c1_r;
    end
  end
  wire global_interrupt_enable = s2_r[0];
  wire sleeping = s2_r[6];
  wire bod_en = c2_r[4];
  wire pwrt_off = c2_r[3];
  wire [2:0] osc_mode = c2_r[2:0];
  wire [4:0] rise = s2_r[5:1] & ~s3_r[5:1];
  wire ev_por = rise[0];
  wire ev_bod = rise[1] & bod_en & ~ev_por;
  wire ev_ext = rise[2] & ~ev_por & ~ev_bod;
  wire ev_wdt = rise[3] & ~ev_por & ~ev_bod & ~ev_ext;
  wire ev_int = rise[4] & sleeping & ~ev_por & ~ev_bod & ~ev_ext & ~ev_wdt;
  wire wdt_wake = ev_wdt & sleeping;
  wire wdt_rst = ev_wdt & ~sleeping;
  wire any_reset = ev_por | ev_bod | ev_ext | wdt_rst;
  wire powerup = ev_por | ev_bod;
  // Registers
  logic [7:0] status_r, status_nxt;
  logic [1:0] pwr_r, pwr_nxt;
  logic [7:0] opt_r;
  logic [5:0] dir_r;
  logic [7:0] pcl_r;
  logic [12:0] pc_r;
  logic pc_stb_r;
  logic vec_pend_r;
  logic bus_we;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  wire wr_status = bus_we && wr_addr == OFS_STATUS && S_AXI_WSTRB[0];
  wire wr_pwr = bus_we && wr_addr == OFS_PWRCTL && S_AXI_WSTRB[0];
  wire wr_opt = bus_we && wr_addr == OFS_OPTDIR && S_AXI_WSTRB[0];
  wire wr_dir = bus_we && wr_addr == OFS_OPTDIR && S_AXI_WSTRB[1];
  always_comb begin
    status_nxt = status_r;
    pwr_nxt = pwr_r;
    if (wr_status) status_nxt = {wr_data[7:5], status_r[BIT_TO:BIT_PD], wr_data[2:0]};
    if (wr_pwr) pwr_nxt = wr_data[1:0] & PWRCTL_MASK;
    if (ev_por) begin
      status_nxt = {STATUS_POR_VAL[7:3], status_r[2:0]};
      pwr_nxt[BIT_POWERON] = 1'b0;
    end else if (ev_bod) begin
      status_nxt = {STATUS_POR_VAL[7:3], status_r[2:0]};
      pwr_nxt[BIT_BROWNOUT] = 1'b0;
      pwr_nxt[BIT_POWERON] = 1'b1;
    end else if (ev_ext) begin
      status_nxt[7:5] = 3'h0;
      if (sleeping) begin
        status_nxt[BIT_TO] = 1'b1;
        status_nxt[BIT_PD] = 1'b0;
      end
    end else if (wdt_rst) begin
      status_nxt[7:5] = 3'h0;
      status_nxt[BIT_TO] = 1'b0;
    end else if (wdt_wake) begin
      status_nxt[BIT_TO] = 1'b0;
      status_nxt[BIT_PD] = 1'b0;
    end else if (ev_int) begin
      status_nxt[BIT_TO] = 1'b1;
      status_nxt[BIT_PD] = 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      status_r <= STATUS_POR_VAL;
      pwr_r <= 2'h0;
    end else begin
      status_r <= status_nxt;
      pwr_r <= pwr_nxt;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      opt_r <= OPTION_RESET;
      dir_r <= DIR_RESET;
    end else if (any_reset) begin
      opt_r <= OPTION_RESET;
      dir_r <= DIR_RESET;
    end else begin
      if (wr_opt) opt_r <= wr_data[7:0];
      if (wr_dir) dir_r <= wr_data[13:8];
    end
  end
  // Program counter selection
  wire [12:0] pc_next = PC_IN + 13'h0001;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pc_r <= PC_RESET;
      pcl_r <= PCL_RESET;
      pc_stb_r <= 1'b0;
      vec_pend_r <= 1'b0;
    end else begin
      pc_stb_r <= any_reset | wdt_wake | ev_int | vec_pend_r;
      vec_pend_r <= ev_int & global_interrupt_enable;
      if (any_reset) begin
        pc_r <= PC_RESET;
        pcl_r <= PCL_RESET;
      end else if (vec_pend_r) begin
        pc_r <= PC_VECTOR;
        pcl_r <= PC_VECTOR[7:0];
      end else if (wdt_wake | ev_int) begin
        pc_r <= pc_next;
        pcl_r <= pc_next[7:0];
      end
    end
  end
  // Start-up delay sequencer
  startup_timer_if tif ();
  startup_timer u_tmr (.clk(CORE_CLK), .rst(RST), .t(tif));
  seq_state_type st_r, st_nxt;
  logic hold_r;
  wire crystal = osc_mode == OSC_LOW || osc_mode == OSC_MEDIUM || osc_mode == OSC_HIGH;
  wire use_pwrt = powerup & ~pwrt_off;
  wire need_ost = crystal & (powerup | wdt_wake | ev_int);
  logic ost_after_r;
  always_comb begin
    st_nxt = st_r;
    tif.start = 1'b0;
    tif.load = 32'h0;
    unique case (st_r)
      ST_HOLD: begin
        if (use_pwrt) begin
          st_nxt = ST_PWRT;
          tif.start = 1'b1;
          tif.load = PWRT_COUNT;
        end else if (need_ost) begin
          st_nxt = ST_OST;
          tif.start = 1'b1;
          tif.load = OST_COUNT;
        end
      end
      ST_PWRT: begin
        if (tif.done) begin
          st_nxt = ost_after_r ? ST_OST : ST_HOLD;
          tif.start = ost_after_r;
          tif.load = ost_after_r ? OST_COUNT : 32'h0;
        end
      end
      ST_OST: begin
        if (tif.done) st_nxt = ST_HOLD;
      end
    endcase
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_r <= ST_HOLD;
      ost_after_r <= 1'b0;
      hold_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_HOLD) ost_after_r <= crystal;
      hold_r <= (st_nxt != ST_HOLD) || (any_reset && !use_pwrt && !need_ost);
    end
  end
  // AXI4-Lite slave
  logic aw_ok_r, w_ok_r, bvalid_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  assign S_AXI_AWREADY = !aw_ok_r && !bvalid_r;
  assign S_AXI_WREADY = !w_ok_r && !bvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  wire aw_now = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_now = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_addr = aw_now ? S_AXI_AWADDR : awaddr_r;
  assign wr_data = w_now ? S_AXI_WDATA : wdata_r;
  assign bus_we = (aw_ok_r || aw_now) && (w_ok_r || w_now);
  wire wr_hit = wr_addr == OFS_STATUS || wr_addr == OFS_PWRCTL || wr_addr == OFS_OPTDIR;
  wire [11:0] ra = S_AXI_ARADDR;
  wire rd_hit = ra == OFS_STATUS || ra == OFS_PWRCTL || ra == OFS_CTRL || ra == OFS_PC
                || ra == OFS_DELAY || ra == OFS_OPTDIR;
  wire [31:0] rd_mux =
    ra == OFS_STATUS ? {24'h0, status_r} :
    ra == OFS_PWRCTL ? {30'h0, pwr_r} :
    ra == OFS_CTRL ? {26'h0, bod_en, pwrt_off, sleeping, osc_mode} :
    ra == OFS_PC ? {11'h0, pcl_r, pc_r} :
    ra == OFS_DELAY ? {29'h0, st_r} :
    ra == OFS_OPTDIR ? {18'h0, dir_r, opt_r} : 32'h0;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= 12'h0;
      wdata_r <= 32'h0;
      rdata_r <= 32'h0;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
    end else begin
      if (aw_now) awaddr_r <= S_AXI_AWADDR;
      if (w_now) wdata_r <= S_AXI_WDATA;
      if (bus_we) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_now) aw_ok_r <= 1'b1;
        if (w_now) w_ok_r <= 1'b1;
        if (bvalid_r && S_AXI_BREADY) bvalid_r <= 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && S_AXI_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign CORE_RESET = hold_r;
  assign PC_LOAD = pc_r;
  assign PC_LOAD_STB = pc_stb_r;
  assign OPTION_VALUE = opt_r;
  assign PIN_DIRECTION = dir_r;
endmodule : reset_cause_status_logic

// file: verification/reset_cause_status_logic_monitor.sv
`timescale 1ns/1ps
module reset_cause_status_logic_monitor
  import rstcause_pkg::*;
(
  input logic CORE_CLK,
  input logic RST,
  input logic POWERON_EVT,
  input logic EXT_RESET_EVT,
  input logic WATCHDOG_EVT,
  input logic INT_WAKE_EVT,
  input logic SLEEPING,
  input logic GLOBAL_INTERRUPT_ENABLE,
  input logic POWERUP_TIMER_DISABLE,
  input logic [12:0] PC_IN,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic S_AXI_RVALID,
  input logic CORE_RESET,
  input logic [12:0] PC_LOAD,
  input logic PC_LOAD_STB,
  input logic [7:0] OPTION_VALUE,
  input logic [5:0] PIN_DIRECTION
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_por_holds_core: assert property (
    $rose(POWERON_EVT) && !POWERUP_TIMER_DISABLE |-> ##[2:6] CORE_RESET)
    else $error("core not held after power-on");
  a_wdt_pc_zero: assert property (
    $rose(WATCHDOG_EVT) && !SLEEPING |-> ##[3:8] PC_LOAD_STB && PC_LOAD == PC_RESET)
    else $error("watchdog reset pc wrong");
  a_reset_opt_ones: assert property (
    $rose(WATCHDOG_EVT) && !SLEEPING |-> ##[3:8] OPTION_VALUE == OPTION_RESET
    && PIN_DIRECTION == DIR_RESET) else $error("option or direction not reset");
  a_wake_keeps_opt: assert property (
    SLEEPING && $rose(WATCHDOG_EVT) |=> $stable({OPTION_VALUE, PIN_DIRECTION})[*8])
    else $error("wake-up changed option or direction");
  a_wake_pc_next: assert property (
    SLEEPING && $rose(WATCHDOG_EVT) |-> ##[3:16] PC_LOAD_STB && PC_LOAD == PC_IN + 13'h1)
    else $error("wake-up pc not next address");
  a_int_vector: assert property (
    SLEEPING && GLOBAL_INTERRUPT_ENABLE && $rose(INT_WAKE_EVT) |-> ##[3:16]
    (PC_LOAD_STB && PC_LOAD == PC_IN + 13'h1) ##1 (PC_LOAD_STB && PC_LOAD == PC_VECTOR))
    else $error("interrupt wake-up vector missing");
  a_ext_pc_zero: assert property (
    $rose(EXT_RESET_EVT) |-> ##[3:16] PC_LOAD_STB && PC_LOAD == PC_RESET)
    else $error("external reset pc wrong");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
  cover property (PC_LOAD_STB && PC_LOAD == PC_VECTOR);
  cover property ($fell(CORE_RESET));
  cover property (S_AXI_RVALID);
endmodule : reset_cause_status_logic_monitor
bind reset_cause_status_logic reset_cause_status_logic_monitor mon_u (.CORE_CLK, .RST,
  .POWERON_EVT, .EXT_RESET_EVT, .WATCHDOG_EVT, .INT_WAKE_EVT, .SLEEPING,
  .GLOBAL_INTERRUPT_ENABLE, .POWERUP_TIMER_DISABLE, .PC_IN, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID, .CORE_RESET, .PC_LOAD, .PC_LOAD_STB, .OPTION_VALUE,
  .PIN_DIRECTION);

// file: verification/reset_cause_status_logic_test.sv
`timescale 1ns/1ps
module reset_cause_status_logic_test
  import rstcause_pkg::*;
;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [4:0] ev = 5'h00;
  wire POWERON_EVT = ev[0];
  wire BROWNOUT_EVT = ev[1];
  wire EXT_RESET_EVT = ev[2];
  wire WATCHDOG_EVT = ev[3];
  wire INT_WAKE_EVT = ev[4];
  logic SLEEPING = 1'b0;
  logic GLOBAL_INTERRUPT_ENABLE = 1'b0;
  logic POWERUP_TIMER_DISABLE = 1'b0;
  logic BROWNOUT_DETECTOR_ENABLE = 1'b1;
  logic [2:0] OSC_MODE = OSC_RC;
  logic [12:0] PC_IN = 13'h0123;
  logic [11:0] S_AXI_AWADDR = 12'h000;
  logic [11:0] S_AXI_ARADDR = 12'h000;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic CORE_RESET, PC_LOAD_STB;
  logic [12:0] PC_LOAD;
  logic [7:0] OPTION_VALUE;
  logic [5:0] PIN_DIRECTION;
  int fails = 0;
  int checks_done = 0;
  reset_cause_status_logic #(.PWRT_COUNT(20), .OST_COUNT(8)) dut_u (.CORE_CLK, .RST,
    .POWERON_EVT, .BROWNOUT_EVT, .EXT_RESET_EVT, .WATCHDOG_EVT, .INT_WAKE_EVT, .SLEEPING,
    .GLOBAL_INTERRUPT_ENABLE, .POWERUP_TIMER_DISABLE, .BROWNOUT_DETECTOR_ENABLE, .OSC_MODE,
    .PC_IN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .CORE_RESET, .PC_LOAD, .PC_LOAD_STB, .OPTION_VALUE,
    .PIN_DIRECTION);
  always #25 CORE_CLK = ~CORE_CLK;
  task automatic finish_test;
    $display("Checks %0d, errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'b111};
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    cmp({30'h0, S_AXI_BRESP}, {30'h0, RESP_OKAY});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY,
    input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge CORE_CLK);
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    cmp(S_AXI_RDATA & m, e);
    cmp({30'h0, S_AXI_RRESP}, {30'h0, r});
  endtask : rd
  task automatic evt(input int i, input int lo, input int hi, input logic [12:0] pc);
    int c;
    c = 0;
    @(posedge CORE_CLK);
    ev[i] <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    ev[i] <= 1'b0;
    repeat (60) begin
      @(posedge CORE_CLK);
      c += int'(CORE_RESET === 1'b1);
    end
    cmp({31'h0, c >= lo && c <= hi}, 32'h1);
    cmp({19'h0, PC_LOAD}, {19'h0, pc});
  endtask : evt
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RST <= 1'b0;
    rd(OFS_STATUS, 32'h18);
    rd(OFS_PWRCTL, 32'h0);
    rd(OFS_OPTDIR, 32'h3FFF);
    rd(12'h100, 32'h0, RESP_SLVERR);
    wr(OFS_PWRCTL, 32'hFF);
    rd(OFS_PWRCTL, 32'h3);
    wr(OFS_STATUS, 32'hFF);
    evt(1, 20, 25, 13'h0);
    rd(OFS_PWRCTL, 32'h2);
    rd(OFS_STATUS, 32'h1F);
    wr(OFS_PWRCTL, 32'h3);
    wr(OFS_STATUS, 32'hFF);
    wr(OFS_OPTDIR, 32'h1234);
    evt(3, 0, 3, 13'h0);
    rd(OFS_STATUS, 32'h0F);
    rd(OFS_PWRCTL, 32'h3);
    rd(OFS_OPTDIR, 32'h3FFF);
    SLEEPING <= 1'b1;
    evt(2, 0, 3, 13'h0);
    rd(OFS_STATUS, 32'h17);
    SLEEPING <= 1'b0;
    wr(OFS_STATUS, 32'hFF);
    evt(2, 0, 3, 13'h0);
    rd(OFS_STATUS, 32'h17);
    wr(OFS_STATUS, 32'hFF);
    wr(OFS_OPTDIR, 32'h1234);
    SLEEPING <= 1'b1;
    OSC_MODE <= OSC_MEDIUM;
    evt(3, 8, 13, 13'h0124);
    rd(OFS_STATUS, 32'hE7);
    rd(OFS_OPTDIR, 32'h1234);
    OSC_MODE <= OSC_RC;
    GLOBAL_INTERRUPT_ENABLE <= 1'b1;
    evt(4, 0, 3, PC_VECTOR);
    rd(OFS_STATUS, 32'hF7);
    rd(OFS_PC, 32'h8004);
    SLEEPING <= 1'b0;
    GLOBAL_INTERRUPT_ENABLE <= 1'b0;
    POWERUP_TIMER_DISABLE <= 1'b1;
    evt(0, 0, 3, 13'h0);
    rd(OFS_PWRCTL, 32'h1);
    rd(OFS_STATUS, 32'h18, RESP_OKAY, 32'hF8);
    OSC_MODE <= OSC_HIGH;
    evt(1, 8, 13, 13'h0);
    rd(OFS_PWRCTL, 32'h2);
    rd(OFS_CTRL, 32'h32);
    POWERUP_TIMER_DISABLE <= 1'b0;
    evt(0, 28, 33, 13'h0);
    rd(OFS_PWRCTL, 32'h0);
    wr(OFS_PWRCTL, 32'h3);
    BROWNOUT_DETECTOR_ENABLE <= 1'b0;
    evt(1, 0, 0, 13'h0);
    rd(OFS_PWRCTL, 32'h3);
    finish_test();
  end
endmodule : reset_cause_status_logic_test
